/* File: sfm_pkg.sv */
package sfm_pkg;

  // =====================================================================
  // Threshold encoding: one unit is 0.5 % of rated frequency.
  // =====================================================================
  localparam logic [7:0] UF_DROP_RST = 8'hBE;  // 95 %
  localparam logic [7:0] UF_PICK_RST = 8'hC2;  // 97 %
  localparam logic [7:0] UF_DROP_MIN = 8'hA0;  // 80 %
  localparam logic [7:0] UF_DROP_MAX = 8'hBE;  // 95 %
  localparam logic [7:0] UF_PICK_MIN = 8'hAA;  // 85 %
  localparam logic [7:0] UF_PICK_MAX = 8'hC8;  // 100 %
  localparam logic [7:0] OF_DROP_RST = 8'hD2;  // 105 %
  localparam logic [7:0] OF_PICK_RST = 8'hCA;  // 101 %
  localparam logic [7:0] OF_DROP_MIN = 8'hCA;  // 101 %
  localparam logic [7:0] OF_DROP_MAX = 8'hF0;  // 120 %
  localparam logic [7:0] OF_PICK_MIN = 8'hC8;  // 100 %
  localparam logic [7:0] OF_PICK_MAX = 8'hE6;  // 115 %
  localparam logic [7:0] MIN_DIFF    = 8'h01;  // 0.5 %
  // Measured frequency is in 0.1 % units, five per threshold unit.
  localparam logic [10:0] FREQ_SCALE = 11'h005;

  // =====================================================================
  // Confirmation delay, counted in 0.1 s ticks.
  // =====================================================================
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS       = 100_000_000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam logic [14:0] DELAY_RST     = 15'h001E;  // 3 s
  localparam logic [14:0] DELAY_MAX     = 15'h4650;  // 1800 s

  // =====================================================================
  // Unbalance and rotation.
  // =====================================================================
  localparam logic [4:0] UNB_PCT_MIN = 5'h02;
  localparam logic [4:0] UNB_PCT_MAX = 5'h1E;
  localparam logic [4:0] UNB_PCT_RST = 5'h0A;
  localparam logic [8:0] ROT_ABC     = 9'h078;  // 120 degrees
  localparam logic [8:0] ROT_CBA     = 9'h0F0;  // 240 degrees
  localparam logic [8:0] ROT_TOL     = 9'h005;

  // =====================================================================
  // Register word addresses and control bits.
  // =====================================================================
  localparam logic [3:0] A_UF_DROP  = 4'h0;
  localparam logic [3:0] A_UF_PICK  = 4'h1;
  localparam logic [3:0] A_OF_DROP  = 4'h2;
  localparam logic [3:0] A_OF_PICK  = 4'h3;
  localparam logic [3:0] A_DELAY    = 4'h4;
  localparam logic [3:0] A_CTRL     = 4'h5;
  localparam logic [3:0] A_UNB_PCT  = 4'h6;
  localparam logic [3:0] A_STATUS   = 4'h7;
  localparam logic [3:0] A_CNT_OK   = 4'h8;
  localparam logic [3:0] A_CNT_FAIL = 4'h9;
  localparam int unsigned CTRL_UNB_EN = 0;
  localparam int unsigned CTRL_ROT_EN = 1;
  localparam int unsigned CTRL_3W     = 2;
  localparam logic [2:0] CTRL_RST     = 3'h2;

  typedef enum logic [2:0] {
    SFM_OK   = 3'b001,
    SFM_PEND = 3'b010,
    SFM_OUT  = 3'b100
  } sfm_mon_t;

endpackage

/* File: sfm_monitor.sv */
`timescale 1ns/1ps
// Contract
// - Under-frequency dropout resets to 95 %, pickup to 97 % of rated.
// - Under-frequency dropout limited to 80-95 %, pickup to 85-100 %.
// - Under-frequency thresholds move only in 0.5 % steps.
// - Display dropout write breaking differential rewrites pickup to dropout minus 0.5 %.
// - Fieldbus write stores dropout; non-compliant pickup becomes dropout minus 0.5 %.
// - Frequency below dropout longer than confirmation delay means out of range.
// - Frequency at or above pickup means acceptable again.
// - Over-frequency dropout resets to 105 %, pickup to 101 % of rated.
// - Over-frequency dropout limited to 101-120 %, pickup to 100-115 %.
// - Over-frequency thresholds move only in 0.5 % steps.
// - Display over-frequency dropout breaking 0.5 % gap rewrites pickup.
// - Fieldbus over-frequency write stores dropout and repairs a short pickup gap.
// - Unbalance fails when largest deviation exceeds set percent of average.
// - Unbalance check applies only to three-phase three-wire systems.
// - Unbalance check off after reset; when on, it alarms and requests transfer.
// - Unbalance threshold limited to 2-30 %.
// - Rotation is checked on the opposite source, only with both present.
// - Only A-B-C is correct; C-B-A is wrong and blocks transfer.
// - Rotation check on after reset and switchable by configuration.
// - A-to-B angle accepted only at 120 degrees within 5 degrees; 240 degrees counts as wrong.
// - Successful and failed transfers are counted separately.
// - Confirmation delay defaults to 3 s, adjustable from 0 to 1800 s.
module sfm_monitor #(
  parameter int unsigned TICK_CYCLES = sfm_pkg::TICK_CYC,
  parameter int unsigned CNT_W       = 16
) (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              nrst,
  // Fieldbus register port.
  input  wire logic [3:0]        bus_addr,
  input  wire logic [15:0]       bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [15:0]       bus_rdata,
  // Local display threshold entry.
  input  wire logic              disp_wr,
  input  wire logic [1:0]        disp_sel,
  input  wire logic [7:0]        disp_value,
  // Measurements.
  input  wire logic [10:0]       freq_meas,
  input  wire logic [15:0]       volt_a,
  input  wire logic [15:0]       volt_b,
  input  wire logic [15:0]       volt_c,
  input  wire logic              conn_alt,
  input  wire logic              norm_present,
  input  wire logic              alt_present,
  input  wire logic [8:0]        norm_ang_ab,
  input  wire logic [8:0]        alt_ang_ab,
  // Transfer outcome events.
  input  wire logic              xfer_ok,
  input  wire logic              xfer_fail,
  // Status outputs.
  output logic                   uf_fail,
  output logic                   of_fail,
  output logic                   unb_alarm,
  output logic                   rot_wrong,
  output logic                   xfer_req,
  output logic                   xfer_block
);

  // =====================================================================
  // Helpers.
  // =====================================================================
  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Pulls a too-close pickup to dropout less one step, clamped to the pickup range.
  function automatic logic [7:0] fix_pick(input logic [7:0] drop, input logic [7:0] pick,
                                          input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] gap;
    gap = (drop > pick) ? (drop - pick) : (pick - drop);
    fix_pick = (gap < sfm_pkg::MIN_DIFF) ? clamp8(drop - sfm_pkg::MIN_DIFF, lo, hi) : pick;
  endfunction

  function automatic logic near_ang(input logic [8:0] a, input logic [8:0] ref_ang);
    near_ang = (a >= ref_ang - sfm_pkg::ROT_TOL) && (a <= ref_ang + sfm_pkg::ROT_TOL);
  endfunction

  // =====================================================================
  // Configuration registers.
  // =====================================================================
  logic [7:0]  uf_drop_r, uf_drop_nxt, uf_pick_r, uf_pick_nxt;
  logic [7:0]  of_drop_r, of_drop_nxt, of_pick_r, of_pick_nxt;
  logic [14:0] delay_r, delay_nxt;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [4:0]  unb_pct_r, unb_pct_nxt;
  logic        thr_we;
  logic [1:0]  thr_sel;
  logic [7:0]  thr_val;

  always_comb begin
    uf_drop_nxt = uf_drop_r;
    uf_pick_nxt = uf_pick_r;
    of_drop_nxt = of_drop_r;
    of_pick_nxt = of_pick_r;
    delay_nxt   = delay_r;
    ctrl_nxt    = ctrl_r;
    unb_pct_nxt = unb_pct_r;
    // The fieldbus wins a threshold write that meets the display.
    thr_we  = disp_wr || (bus_wr && bus_addr <= sfm_pkg::A_OF_PICK);
    thr_sel = (bus_wr && bus_addr <= sfm_pkg::A_OF_PICK) ? bus_addr[1:0] : disp_sel;
    thr_val = (bus_wr && bus_addr <= sfm_pkg::A_OF_PICK) ? bus_wdata[7:0] : disp_value;
    // Each code unit is one 0.5 % step, so every value lies on the step grid.
    if (thr_we) begin
      unique case (thr_sel)
        2'h0: begin
          uf_drop_nxt = clamp8(thr_val, sfm_pkg::UF_DROP_MIN, sfm_pkg::UF_DROP_MAX);
          uf_pick_nxt = fix_pick(uf_drop_nxt, uf_pick_r, sfm_pkg::UF_PICK_MIN,
                                 sfm_pkg::UF_PICK_MAX);
        end
        2'h1: begin
          uf_pick_nxt = fix_pick(uf_drop_r,
                                 clamp8(thr_val, sfm_pkg::UF_PICK_MIN, sfm_pkg::UF_PICK_MAX),
                                 sfm_pkg::UF_PICK_MIN, sfm_pkg::UF_PICK_MAX);
        end
        2'h2: begin
          of_drop_nxt = clamp8(thr_val, sfm_pkg::OF_DROP_MIN, sfm_pkg::OF_DROP_MAX);
          of_pick_nxt = fix_pick(of_drop_nxt, of_pick_r, sfm_pkg::OF_PICK_MIN,
                                 sfm_pkg::OF_PICK_MAX);
        end
        2'h3: begin
          of_pick_nxt = fix_pick(of_drop_r,
                                 clamp8(thr_val, sfm_pkg::OF_PICK_MIN, sfm_pkg::OF_PICK_MAX),
                                 sfm_pkg::OF_PICK_MIN, sfm_pkg::OF_PICK_MAX);
        end
      endcase
    end
    if (bus_wr) begin
      if (bus_addr == sfm_pkg::A_DELAY) begin
        delay_nxt = (bus_wdata[14:0] > sfm_pkg::DELAY_MAX) ? sfm_pkg::DELAY_MAX
                                                           : bus_wdata[14:0];
      end
      if (bus_addr == sfm_pkg::A_CTRL) begin
        ctrl_nxt = bus_wdata[2:0];
      end
      if (bus_addr == sfm_pkg::A_UNB_PCT) begin
        if (bus_wdata[15:5] != 11'h000) begin
          unb_pct_nxt = sfm_pkg::UNB_PCT_MAX;
        end else begin
          unb_pct_nxt = (bus_wdata[4:0] < sfm_pkg::UNB_PCT_MIN) ? sfm_pkg::UNB_PCT_MIN :
                        ((bus_wdata[4:0] > sfm_pkg::UNB_PCT_MAX) ? sfm_pkg::UNB_PCT_MAX :
                         bus_wdata[4:0]);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uf_drop_r <= sfm_pkg::UF_DROP_RST;
      uf_pick_r <= sfm_pkg::UF_PICK_RST;
      of_drop_r <= sfm_pkg::OF_DROP_RST;
      of_pick_r <= sfm_pkg::OF_PICK_RST;
      delay_r   <= sfm_pkg::DELAY_RST;
      ctrl_r    <= sfm_pkg::CTRL_RST;
      unb_pct_r <= sfm_pkg::UNB_PCT_RST;
    end else begin
      uf_drop_r <= uf_drop_nxt;
      uf_pick_r <= uf_pick_nxt;
      of_drop_r <= of_drop_nxt;
      of_pick_r <= of_pick_nxt;
      delay_r   <= delay_nxt;
      ctrl_r    <= ctrl_nxt;
      unb_pct_r <= unb_pct_nxt;
    end
  end

  // =====================================================================
  // Delay tick of 0.1 s.
  // =====================================================================
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic        tick;

  always_comb begin
    tick         = (tick_cnt_r == TICK_CYCLES[31:0] - 32'h1);
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // =====================================================================
  // Frequency monitors: index 0 under, index 1 over.
  // =====================================================================
  logic [1:0]  beyond, back;
  logic [1:0]  fail_r, fail_nxt;

  always_comb begin
    beyond[0] = freq_meas < ({3'h0, uf_drop_r} * sfm_pkg::FREQ_SCALE);
    back[0]   = freq_meas >= ({3'h0, uf_pick_r} * sfm_pkg::FREQ_SCALE);
    beyond[1] = freq_meas > ({3'h0, of_drop_r} * sfm_pkg::FREQ_SCALE);
    back[1]   = freq_meas <= ({3'h0, of_pick_r} * sfm_pkg::FREQ_SCALE);
  end

  for (genvar i = 0; i < 2; i++) begin : g_mon
    sfm_pkg::sfm_mon_t st_r, st_nxt;
    logic [14:0]       cnt_r, cnt_nxt;

    always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      unique case (st_r)
        sfm_pkg::SFM_OK: begin
          if (beyond[i]) begin
            st_nxt  = sfm_pkg::SFM_PEND;
            cnt_nxt = 15'h0000;
          end
        end
        sfm_pkg::SFM_PEND: begin
          if (!beyond[i]) begin
            st_nxt = sfm_pkg::SFM_OK;
          end else if (tick) begin
            if (cnt_r >= delay_r) begin
              st_nxt = sfm_pkg::SFM_OUT;
            end else begin
              cnt_nxt = cnt_r + 15'h0001;
            end
          end
        end
        sfm_pkg::SFM_OUT: begin
          if (back[i]) begin
            st_nxt = sfm_pkg::SFM_OK;
          end
        end
        default: begin
          st_nxt = sfm_pkg::SFM_OK;
        end
      endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        st_r  <= sfm_pkg::SFM_OK;
        cnt_r <= 15'h0000;
      end else begin
        st_r  <= st_nxt;
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Both fail flags live in one register so each bit has a single driver.
  always_comb begin
    fail_nxt[0] = (g_mon[0].st_nxt == sfm_pkg::SFM_OUT);
    fail_nxt[1] = (g_mon[1].st_nxt == sfm_pkg::SFM_OUT);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_r <= 2'h0;
    end else begin
      fail_r <= fail_nxt;
    end
  end

  // =====================================================================
  // Unbalance, rotation and transfer request.
  // =====================================================================
  logic [17:0] vsum;
  logic [17:0] dev [3];
  logic [17:0] dev_max;
  logic [25:0] lhs, rhs;
  logic [8:0]  opp_ang;
  logic        unb_nxt, rot_nxt, req_nxt;
  logic        unb_r, rot_r, req_r, blk_r;

  always_comb begin
    // Deviation times three against the sum avoids dividing by three.
    vsum = {2'h0, volt_a} + {2'h0, volt_b} + {2'h0, volt_c};
    dev[0] = ({2'h0, volt_a} * 18'h3 > vsum) ? ({2'h0, volt_a} * 18'h3 - vsum)
                                             : (vsum - {2'h0, volt_a} * 18'h3);
    dev[1] = ({2'h0, volt_b} * 18'h3 > vsum) ? ({2'h0, volt_b} * 18'h3 - vsum)
                                             : (vsum - {2'h0, volt_b} * 18'h3);
    dev[2] = ({2'h0, volt_c} * 18'h3 > vsum) ? ({2'h0, volt_c} * 18'h3 - vsum)
                                             : (vsum - {2'h0, volt_c} * 18'h3);
    dev_max = (dev[0] > dev[1]) ? dev[0] : dev[1];
    dev_max = (dev[2] > dev_max) ? dev[2] : dev_max;
    lhs = {8'h00, dev_max} * 26'h64;
    rhs = {21'h0, unb_pct_r} * {8'h00, vsum};
    unb_nxt = ctrl_r[sfm_pkg::CTRL_UNB_EN] && ctrl_r[sfm_pkg::CTRL_3W]
              && (lhs > rhs);
    opp_ang = conn_alt ? norm_ang_ab : alt_ang_ab;
    // Anything but A-B-C, including C-B-A, counts as wrong.
    rot_nxt = ctrl_r[sfm_pkg::CTRL_ROT_EN] && norm_present && alt_present
              && (near_ang(opp_ang, sfm_pkg::ROT_CBA)
                  || !near_ang(opp_ang, sfm_pkg::ROT_ABC));
    req_nxt = fail_r[0] || fail_r[1] || unb_nxt;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unb_r <= 1'b0;
      rot_r <= 1'b0;
      req_r <= 1'b0;
      blk_r <= 1'b0;
    end else begin
      unb_r <= unb_nxt;
      rot_r <= rot_nxt;
      req_r <= req_nxt;
      blk_r <= rot_nxt;
    end
  end

  // =====================================================================
  // Transfer counters; a clear and an event in the same cycle leave a count of one.
  // =====================================================================
  logic [CNT_W-1:0] cnt_ok_r, cnt_ok_nxt, cnt_fail_r, cnt_fail_nxt;

  always_comb begin
    cnt_ok_nxt   = (bus_wr && bus_addr == sfm_pkg::A_CNT_OK) ? '0 : cnt_ok_r;
    cnt_fail_nxt = (bus_wr && bus_addr == sfm_pkg::A_CNT_FAIL) ? '0 : cnt_fail_r;
    if (xfer_ok && cnt_ok_nxt != '1) begin
      cnt_ok_nxt = cnt_ok_nxt + 1'b1;
    end
    if (xfer_fail && cnt_fail_nxt != '1) begin
      cnt_fail_nxt = cnt_fail_nxt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ok_r   <= '0;
      cnt_fail_r <= '0;
    end else begin
      cnt_ok_r   <= cnt_ok_nxt;
      cnt_fail_r <= cnt_fail_nxt;
    end
  end

  // =====================================================================
  // Read port.
  // =====================================================================
  logic [15:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 16'h0000;
    if (bus_rd) begin
      unique case (bus_addr)
        sfm_pkg::A_UF_DROP:  rdata_nxt = {8'h00, uf_drop_r};
        sfm_pkg::A_UF_PICK:  rdata_nxt = {8'h00, uf_pick_r};
        sfm_pkg::A_OF_DROP:  rdata_nxt = {8'h00, of_drop_r};
        sfm_pkg::A_OF_PICK:  rdata_nxt = {8'h00, of_pick_r};
        sfm_pkg::A_DELAY:    rdata_nxt = {1'b0, delay_r};
        sfm_pkg::A_CTRL:     rdata_nxt = {13'h0000, ctrl_r};
        sfm_pkg::A_UNB_PCT:  rdata_nxt = {11'h000, unb_pct_r};
        sfm_pkg::A_STATUS:   rdata_nxt = {10'h000, blk_r, req_r, rot_r, unb_r,
                                          fail_r[1], fail_r[0]};
        sfm_pkg::A_CNT_OK:   rdata_nxt = 16'(cnt_ok_r);
        sfm_pkg::A_CNT_FAIL: rdata_nxt = 16'(cnt_fail_r);
        default:             rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata  = rdata_r;
  assign uf_fail    = fail_r[0];
  assign of_fail    = fail_r[1];
  assign unb_alarm  = unb_r;
  assign rot_wrong  = rot_r;
  assign xfer_req   = req_r;
  assign xfer_block = blk_r;

endmodule  // sfm_monitor

/* File: sfm_src_model.sv */
`timescale 1ns/1ps
// =====================================================================
// Normal and alternate sources as seen through the sensing front end.
// =====================================================================
module sfm_src_model (
  // Sensed values handed to the monitor.
  output logic [10:0] freq_meas,
  output logic [15:0] volt_a,
  output logic [15:0] volt_b,
  output logic [15:0] volt_c,
  output logic        conn_alt,
  output logic        norm_present,
  output logic        alt_present,
  output logic [8:0]  norm_ang_ab,
  output logic [8:0]  alt_ang_ab
);
  // Settings moved by the bench; they start at a healthy rated source.
  logic [10:0] f_set = 11'h3E8;
  logic [15:0] vc    = 16'h03E8;
  logic [2:0]  pres  = 3'b011;
  logic [8:0]  na    = 9'h078;
  logic [8:0]  aa    = 9'h078;
  assign freq_meas    = f_set;
  assign volt_a       = 16'h03E8;
  assign volt_b       = 16'h03E8;
  assign volt_c       = vc;
  assign conn_alt     = pres[2];
  assign norm_present = pres[1];
  assign alt_present  = pres[0];
  assign norm_ang_ab  = na;
  assign alt_ang_ab   = aa;
endmodule // sfm_src_model

/* File: sfm_monitor_assertions.sv */
`timescale 1ns/1ps
// =====================================================================
// Port-level checks of the source monitor.
// =====================================================================
module sfm_monitor_assertions (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        nrst,
  // Bus read side.
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  // Measurements.
  input wire logic [10:0] freq_meas,
  input wire logic        conn_alt,
  input wire logic        norm_present,
  input wire logic        alt_present,
  input wire logic [8:0]  norm_ang_ab,
  input wire logic [8:0]  alt_ang_ab,
  // Status.
  input wire logic        uf_fail,
  input wire logic        of_fail,
  input wire logic        unb_alarm,
  input wire logic        rot_wrong,
  input wire logic        xfer_req,
  input wire logic        xfer_block
);
  logic [8:0] opp_ang;
  assign opp_ang = conn_alt ? norm_ang_ab : alt_ang_ab;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_both;
    norm_present && alt_present;
  endsequence
  sequence s_abc;
    opp_ang >= 9'h073 && opp_ang <= 9'h07D;
  endsequence
  chk_rot_correct:
    assert property (s_both ##0 s_abc |=> !rot_wrong) else $error("correct angle flagged");
  chk_rot_absent:
    assert property (!(norm_present && alt_present) |=> !rot_wrong) else $error("rotation alone");
  chk_block_rot:
    assert property (xfer_block == rot_wrong) else $error("block differs from rotation");
  chk_unb_req:
    assert property (unb_alarm |-> xfer_req) else $error("unbalance without transfer");
  chk_rdata_idle:
    assert property ($past(bus_rd) == 1'b0 |-> bus_rdata == 16'h0000) else $error("stray data");
  chk_uf_cause:
    assert property ($rose(uf_fail) |-> $past(freq_meas, 2) < 11'h3B6) else $error("uf no cause");
  chk_of_cause:
    assert property ($rose(of_fail) |-> $past(freq_meas, 2) > 11'h3F1) else $error("of no cause");
  chk_uf_recover:
    assert property (freq_meas >= 11'h3E8 |-> ##2 !uf_fail) else $error("uf not recovered");
  chk_of_recover:
    assert property (freq_meas <= 11'h3E8 |-> ##2 !of_fail) else $error("of not recovered");
endmodule // sfm_monitor_assertions

bind sfm_monitor sfm_monitor_assertions sfm_monitor_assertions_i (
  .clk, .nrst, .bus_rd, .bus_rdata, .freq_meas, .conn_alt, .norm_present, .alt_present,
  .norm_ang_ab, .alt_ang_ab, .uf_fail, .of_fail, .unb_alarm, .rot_wrong, .xfer_req,
  .xfer_block
);

/* File: tb_sfm_monitor.sv */
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the source monitor.
// =====================================================================
module tb_sfm_monitor;
  localparam int TICK = 10;
  typedef struct {logic dsp; logic [3:0] a; logic [15:0] d; logic [3:0] ra; logic [15:0] e;} sfm_op_t;
  typedef struct {logic [2:0] p; logic [8:0] na; logic [8:0] aa; logic e;} sfm_rot_t;
  logic        clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, disp_wr = 1'b0;
  logic        xfer_ok = 1'b0, xfer_fail = 1'b0;
  logic [3:0]  bus_addr = 4'h0;
  logic [15:0] bus_wdata = 16'h0000, bus_rdata, volt_a, volt_b, volt_c;
  logic [1:0]  disp_sel = 2'h0;
  logic [7:0]  disp_value = 8'h00;
  logic [10:0] freq_meas;
  logic [8:0]  norm_ang_ab, alt_ang_ab;
  logic        conn_alt, norm_present, alt_present;
  logic        uf_fail, of_fail, unb_alarm, rot_wrong, xfer_req, xfer_block;
  int          n_errors = 0, samples_checked = 0, n;
  logic [15:0] rst_exp [10] = '{16'h00BE, 16'h00C2, 16'h00D2, 16'h00CA, 16'h001E, 16'h0002,
                                16'h000A, 16'h0000, 16'h0000, 16'h0000};
  sfm_op_t ops [15] = '{
    '{1'b0, 4'h0, 16'h0050, 4'h0, 16'h00A0}, '{1'b0, 4'h1, 16'h00FF, 4'h1, 16'h00C8},
    '{1'b0, 4'h1, 16'h0000, 4'h1, 16'h00AA}, '{1'b0, 4'h0, 16'h00B4, 4'h0, 16'h00B4},
    '{1'b0, 4'h1, 16'h00B4, 4'h1, 16'h00B3}, '{1'b1, 4'h0, 16'h00B3, 4'h1, 16'h00B2},
    '{1'b0, 4'h2, 16'h00FF, 4'h2, 16'h00F0}, '{1'b0, 4'h2, 16'h0000, 4'h3, 16'h00C9},
    '{1'b1, 4'h3, 16'h00CD, 4'h3, 16'h00CD}, '{1'b1, 4'h2, 16'h00CD, 4'h3, 16'h00CC},
    '{1'b0, 4'h6, 16'h0001, 4'h6, 16'h0002}, '{1'b0, 4'h6, 16'h003F, 4'h6, 16'h001E},
    '{1'b0, 4'h4, 16'hFFFF, 4'h4, 16'h4650}, '{1'b0, 4'h4, 16'h0002, 4'h4, 16'h0002},
    '{1'b0, 4'h1, 16'h00C2, 4'h1, 16'h00C2}};
  sfm_rot_t rot [9] = '{'{3'b011, 9'h0F0, 9'h078, 1'b0}, '{3'b011, 9'h078, 9'h07D, 1'b0},
    '{3'b011, 9'h078, 9'h07E, 1'b1}, '{3'b011, 9'h078, 9'h073, 1'b0},
    '{3'b011, 9'h078, 9'h072, 1'b1}, '{3'b011, 9'h078, 9'h0F0, 1'b1},
    '{3'b010, 9'h078, 9'h0F0, 1'b0}, '{3'b101, 9'h0F0, 9'h078, 1'b0},
    '{3'b111, 9'h0F0, 9'h078, 1'b1}};

  sfm_monitor #(.TICK_CYCLES(TICK), .CNT_W(4)) sfm_monitor_i (
    .clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .disp_wr, .disp_sel,
    .disp_value, .freq_meas, .volt_a, .volt_b, .volt_c, .conn_alt, .norm_present,
    .alt_present, .norm_ang_ab, .alt_ang_ab, .xfer_ok, .xfer_fail, .uf_fail, .of_fail,
    .unb_alarm, .rot_wrong, .xfer_req, .xfer_block);
  sfm_src_model sfm_src_model_i (
    .freq_meas, .volt_a, .volt_b, .volt_c, .conn_alt, .norm_present, .alt_present,
    .norm_ang_ab, .alt_ang_ab);

  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic flg(input int i);
    return i == 0 ? uf_fail : i == 1 ? of_fail : i == 2 ? unb_alarm : rot_wrong;
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_after(input int k, input int i, input logic exp);
    repeat (k) @(posedge clk);
    @(negedge clk);
    chk_flag(flg(i), exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    chk_val(bus_rdata, exp);
  endtask
  task automatic dw(input logic [1:0] s, input logic [7:0] v);
    @(posedge clk);
    disp_sel   <= s;
    disp_value <= v;
    disp_wr    <= 1'b1;
    @(posedge clk);
    disp_wr <= 1'b0;
  endtask
  task automatic setf(input logic [10:0] f);
    @(posedge clk);
    sfm_src_model_i.f_set <= f;
  endtask
  // Drive a bad frequency, time the trip, then walk back through hysteresis.
  task automatic trip(input int i, input logic [10:0] bad, hold, good, input int lo, hi);
    setf(bad);
    n = 0;
    while (flg(i) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk_flag(n >= lo && n <= hi, 1'b1);
    rd_chk(sfm_pkg::A_STATUS, i == 0 ? 16'h0011 : 16'h0012);
    setf(hold);
    chk_after(5, i, 1'b1);
    setf(good);
    chk_after(3, i, 1'b0);
  endtask
  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 16; i++) rd_chk(4'(i), i < 10 ? rst_exp[i] : 16'h0000);
    foreach (ops[i]) begin
      if (ops[i].dsp) dw(ops[i].a[1:0], ops[i].d[7:0]);
      else wr(ops[i].a, ops[i].d);
      rd_chk(ops[i].ra, ops[i].e);
    end
    setf(11'h37F);
    chk_after(40, 0, 1'b0);
    trip(0, 11'h37E, 11'h3C9, 11'h3CA, TICK, 3 * TICK + 5);
    trip(1, 11'h402, 11'h3FD, 11'h3FC, TICK, 3 * TICK + 5);
    wr(sfm_pkg::A_DELAY, 16'h0000);
    trip(0, 11'h37E, 11'h3C9, 11'h3CA, 1, TICK + 4);
    wr(sfm_pkg::A_UNB_PCT, 16'h0012);
    @(posedge clk);
    sfm_src_model_i.vc <= 16'h0514;
    chk_after(3, 2, 1'b0);
    wr(sfm_pkg::A_CTRL, 16'h0001);
    chk_after(3, 2, 1'b0);
    wr(sfm_pkg::A_CTRL, 16'h0005);
    chk_after(3, 2, 1'b1);
    chk_flag(xfer_req, 1'b1);
    wr(sfm_pkg::A_UNB_PCT, 16'h0013);
    chk_after(3, 2, 1'b0);
    wr(sfm_pkg::A_CTRL, 16'h0002);
    foreach (rot[i]) begin
      @(posedge clk);
      sfm_src_model_i.pres <= rot[i].p;
      sfm_src_model_i.na   <= rot[i].na;
      sfm_src_model_i.aa   <= rot[i].aa;
      chk_after(3, 3, rot[i].e);
      chk_flag(xfer_block, rot[i].e);
    end
    wr(sfm_pkg::A_CTRL, 16'h0000);
    chk_after(3, 3, 1'b0);
    @(posedge clk);
    xfer_ok <= 1'b1;
    repeat (20) @(posedge clk);
    xfer_ok   <= 1'b0;
    xfer_fail <= 1'b1;
    repeat (2) @(posedge clk);
    xfer_fail <= 1'b0;
    rd_chk(sfm_pkg::A_CNT_OK, 16'h000F);
    rd_chk(sfm_pkg::A_CNT_FAIL, 16'h0002);
    wr(sfm_pkg::A_CNT_OK, 16'h0000);
    rd_chk(sfm_pkg::A_CNT_OK, 16'h0000);
    rd_chk(sfm_pkg::A_CNT_FAIL, 16'h0002);
    give_verdict();
  end
endmodule // tb_sfm_monitor
